// ==== hdl/mbs_pkg.sv ====
`default_nettype none
package mbs_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [15:0] REG_ACTIVE_SETPOINT = 16'h0000;
   localparam logic [15:0] REG_PROCESS_VALUE = 16'h0001;
   localparam logic [15:0] REG_OUTPUT_POWER = 16'h0002;
   localparam logic [15:0] REG_DISPLAY_VALUE = 16'h0004;
   localparam logic [15:0] REG_SCREEN_INDEX = 16'h0005;
   localparam logic [15:0] REG_STATUS_ONE = 16'h0006;
   localparam logic [15:0] REG_FIRMWARE_VERSION = 16'h0007;
   localparam logic [15:0] REG_PRODUCT_IDENTITY = 16'h0008;
   localparam logic [15:0] REG_STATUS_TWO = 16'h0009;
   localparam logic [15:0] REG_STATUS_THREE = 16'h000a;
   localparam logic [15:0] REG_INTEGRAL_RATE = 16'h000b;
   localparam logic [15:0] REG_DERIVATIVE_TIME = 16'h000c;
   localparam logic [15:0] REG_PROPORTIONAL_BAND = 16'h000d;
   localparam logic [15:0] REG_PROGRAM_TIME_BASE = 16'h000e;
   localparam logic [15:0] REG_PWM_CYCLE_TIME = 16'h000f;
   localparam logic [15:0] REG_COUNT = 16'h0011;
   localparam logic [15:0] REG_WRITABLE_FROM = 16'h000c;
   // ************************************************************
   // limits and reset values
   // ************************************************************
   localparam logic signed [15:0] DISPLAY_MIN = -16'sd1999;
   localparam logic signed [15:0] DISPLAY_MAX = 16'sd9999;
   localparam logic signed [15:0] INTEGRAL_MAX = 16'sd3000;
   localparam logic signed [15:0] PROPBAND_MAX = 16'sd5000;
   localparam logic signed [15:0] PWM_MIN = 16'sd5;
   localparam logic signed [15:0] PWM_MAX = 16'sd1000;
   localparam logic signed [15:0] TIMEBASE_MAX = 16'sd1;
   localparam logic [15:0] RST_INTEGRAL = 16'h0064;
   localparam logic [15:0] RST_DERIV = 16'h0000;
   localparam logic [15:0] RST_PROPBAND = 16'h0064;
   localparam logic [15:0] RST_TIMEBASE = 16'h0000;
   localparam logic [15:0] RST_PWM = 16'h0032;
   localparam logic [15:0] RST_SETPOINT = 16'h0000;
   localparam logic [15:0] RST_DISPLAY = 16'h0000;
   localparam logic [7:0] NODE_MAX = 8'hf7;
   localparam logic [7:0] BROADCAST_ADDR = 8'h00;
   // ************************************************************
   // function codes and exceptions
   // ************************************************************
   localparam logic [7:0] FC_READ_HOLDING = 8'h03;
   localparam logic [7:0] FC_FORCE_COIL = 8'h05;
   localparam logic [7:0] FC_PRESET_REG = 8'h06;
   localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [15:0] MAX_READ_COUNT = 16'h007d;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLOCK_HZ = 200000000;
   localparam int BAUD_MIN = 1200;
   localparam int BITS_PER_CHAR = 10;
   localparam int SILENCE_CHARS_X2 = 7;
   localparam logic [15:0] BAUD_DIV_MIN =
      16'((CLOCK_HZ / (BAUD_MIN * 16) > 65535) ? 65535 : CLOCK_HZ / (BAUD_MIN * 16));
   localparam logic [15:0] SILENCE_TICKS = 16'((SILENCE_CHARS_X2 * BITS_PER_CHAR * 16) / 2);
   localparam logic [15:0] PRODUCT_ID_DEFAULT = 16'h0a5a;
   localparam logic [15:0] FW_VERSION_DEFAULT = 16'h0064;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } mbs_byte_s;

   typedef struct packed {
      logic signed [15:0] activeSetpoint;
      logic signed [15:0] setpointLowLimit;
      logic signed [15:0] setpointHighLimit;
      logic signed [15:0] processValue;
      logic signed [15:0] outputPower;
      logic signed [15:0] displayValue;
      logic [15:0] screenIndex;
      logic [15:0] statusOne;
      logic [15:0] statusTwo;
      logic [15:0] statusThree;
      logic [1:0] decimalPositionSetting;
   } mbs_proc_s;
endpackage
`default_nettype wire

// ==== hdl/mbs_fifo.sv ====
`default_nettype none
module mbs_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
   } mbs_fifo_s;
   mbs_fifo_s state_reg, state_next;
   logic doWrite, doRead;

   assign inReady = state_reg.count != (AW+1)'(DEPTH);
   assign outValid = state_reg.count != '0;
   assign outData = state_reg.mem[state_reg.rdPtr];
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;

   always_comb begin
      state_next = state_reg;
      if (doWrite) begin
         state_next.mem[state_reg.wrPtr] = inData;
         state_next.wrPtr = (state_reg.wrPtr == AW'(DEPTH-1)) ? '0 : state_reg.wrPtr + 1'b1;
      end
      if (doRead) begin
         state_next.rdPtr = (state_reg.rdPtr == AW'(DEPTH-1)) ? '0 : state_reg.rdPtr + 1'b1;
      end
      if (doWrite && !doRead) begin
         state_next.count = state_reg.count + 1'b1;
      end else if (doRead && !doWrite) begin
         state_next.count = state_reg.count - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/mbs_slave.sv ====
`default_nettype none
module mbs_slave
   import mbs_pkg::*;
#(
   parameter logic [15:0] PRODUCT_ID = PRODUCT_ID_DEFAULT, // arbitrary value
   parameter logic [15:0] FW_VERSION = FW_VERSION_DEFAULT
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic rxPin,
   output logic txData,
   output logic txEnable,
   input wire logic [15:0] lineSpeedSetting,
   input wire logic [7:0] nodeAddress,
   input wire mbs_pkg::mbs_proc_s procIn,
   output logic signed [15:0] screenSetpoint,
   output logic signed [15:0] displayWrite,
   output logic displayWriteStrobe,
   output logic signed [15:0] integralRate,
   output logic signed [15:0] derivativeTime,
   output logic signed [15:0] proportionalBand,
   output logic signed [15:0] programTimeBase,
   output logic signed [15:0] pwmCycleTime,
   output logic coilWriteStrobe,
   output logic [15:0] coilAddress,
   output logic coilValue
);
   import mbs_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RECV = 3'b001,
      ST_EXEC = 3'b010,
      ST_SEND = 3'b011,
      ST_DROP = 3'b100
   } mbs_state_e;

   typedef struct packed {
      mbs_state_e st;
      logic rxS1, rxS2;
      logic [15:0] tickCnt;
      logic [3:0] rxPhase, rxBit;
      logic rxBusy;
      logic [7:0] rxShift;
      logic [15:0] silence;
      logic [7:0] rxCount;
      logic [7:0][7:0] rxBuf;
      logic [15:0] crc;
      logic [7:0] txCount, txLen, txIdx;
      logic [15:0] txCrc;
      logic crcLoHi;
      logic [3:0] txPhase, txBit;
      logic [9:0] txShift;
      logic txBusy, txLine, txEn;
      logic [15:0] regIdx, regLeft;
      logic signed [15:0] sp, disp, ir, dt, pb, tb, ct;
      logic dispStb, coilStb, coilVal;
      logic [15:0] coilAddr;
   } mbs_slave_s;
   mbs_slave_s s_reg, s_next;

   logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
   mbs_byte_s fifoIn, fifoOut;
   logic tick;
   logic [15:0] baudDiv;

   assign baudDiv = (lineSpeedSetting < 16'h0001 || lineSpeedSetting > BAUD_DIV_MIN) ?
      BAUD_DIV_MIN : lineSpeedSetting;
   assign tick = s_reg.tickCnt == 16'h0000;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic signed [15:0] clampS(input logic signed [15:0] v,
                                                 input logic signed [15:0] lo,
                                                 input logic signed [15:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [15:0] readReg(input logic [15:0] a, input mbs_slave_s s,
                                           input mbs_proc_s p);
      case (a)
         REG_ACTIVE_SETPOINT: return p.activeSetpoint;
         REG_PROCESS_VALUE: return p.processValue;
         REG_OUTPUT_POWER: return p.outputPower;
         REG_DISPLAY_VALUE: return p.displayValue;
         REG_SCREEN_INDEX: return p.screenIndex;
         REG_STATUS_ONE: return p.statusOne;
         REG_FIRMWARE_VERSION: return FW_VERSION;
         REG_PRODUCT_IDENTITY: return PRODUCT_ID;
         REG_STATUS_TWO: return p.statusTwo;
         REG_STATUS_THREE: return p.statusThree;
         REG_INTEGRAL_RATE: return s.ir;
         REG_DERIVATIVE_TIME: return s.dt;
         REG_PROPORTIONAL_BAND: return s.pb;
         REG_PROGRAM_TIME_BASE: return s.tb;
         REG_PWM_CYCLE_TIME: return s.ct;
         default: return 16'h0000;
      endcase
   endfunction

   // ************************************************************
   // received byte buffer
   // ************************************************************
   mbs_fifo #(
      .WIDTH($bits(mbs_byte_s)),
      .DEPTH(8)
   ) rxFifo (
      .clock(clock),
      .rst_b(rst_b),
      .inData(fifoIn),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .outData(fifoOut),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady)
   );

   // ************************************************************
   // next state
   // ************************************************************
   logic [7:0] fn;
   logic [15:0] addr, val;
   logic mine, bcast, rxDone;
   logic [7:0] rxByte;
   logic [7:0] b;
   logic [15:0] w;

   always_comb begin
      s_next = s_reg;
      fifoIn = '0;
      fifoInValid = 1'b0;
      fifoOutReady = 1'b0;
      rxDone = 1'b0;
      rxByte = 8'h00;
      b = 8'h00;
      w = 16'h0000;
      fn = s_reg.rxBuf[1];
      addr = {s_reg.rxBuf[2], s_reg.rxBuf[3]};
      val = {s_reg.rxBuf[4], s_reg.rxBuf[5]};
      bcast = s_reg.rxBuf[0] == BROADCAST_ADDR;
      mine = s_reg.rxBuf[0] == nodeAddress && nodeAddress != BROADCAST_ADDR
             && nodeAddress <= NODE_MAX;
      s_next.dispStb = 1'b0;
      s_next.coilStb = 1'b0;
      s_next.rxS1 = rxPin;
      s_next.rxS2 = s_reg.rxS1;
      s_next.tickCnt = tick ? baudDiv - 16'h0001 : s_reg.tickCnt - 16'h0001;

      // receiver: 16x oversampled 8N1
      if (tick) begin
         if (s_reg.silence != 16'hffff) begin
            s_next.silence = s_reg.silence + 16'h0001;
         end
         if (!s_reg.rxBusy) begin
            if (!s_reg.rxS2) begin
               s_next.rxBusy = 1'b1;
               s_next.rxPhase = 4'h0;
               s_next.rxBit = 4'h0;
            end
         end else begin
            s_next.rxPhase = s_reg.rxPhase + 4'h1;
            if (s_reg.rxPhase == 4'h7) begin
               if (s_reg.rxBit == 4'h0 && s_reg.rxS2) begin
                  s_next.rxBusy = 1'b0;
               end else if (s_reg.rxBit == 4'h9) begin
                  s_next.rxBusy = 1'b0;
                  s_next.silence = 16'h0000;
                  rxDone = s_reg.rxS2;
                  rxByte = s_reg.rxShift;
               end else if (s_reg.rxBit != 4'h0) begin
                  s_next.rxShift = {s_reg.rxS2, s_reg.rxShift[7:1]};
               end
            end
            if (s_reg.rxPhase == 4'hf) begin
               s_next.rxBit = s_reg.rxBit + 4'h1;
            end
         end
      end
      fifoIn.data = rxByte;
      fifoIn.last = 1'b0;
      fifoInValid = rxDone;

      // ---- frame engine ----
      case (s_reg.st)
         ST_IDLE: begin
            s_next.rxCount = 8'h00;
            s_next.crc = CRC_INIT;
            if (fifoOutValid) begin
               s_next.st = ST_RECV;
            end
         end
         ST_RECV: begin
            fifoOutReady = 1'b1;
            if (fifoOutValid) begin
               if (s_reg.rxCount < 8'h08) begin
                  s_next.rxBuf[s_reg.rxCount[2:0]] = fifoOut.data;
                  s_next.crc = crcStep(s_reg.crc, fifoOut.data);
                  s_next.rxCount = s_reg.rxCount + 8'h01;
               end else begin
                  s_next.st = ST_DROP;
               end
            end else if (s_reg.silence >= SILENCE_TICKS && !s_reg.rxBusy) begin
               s_next.st = (s_reg.rxCount == 8'h08 && s_reg.crc == 16'h0000) ? ST_EXEC : ST_IDLE;
            end
         end
         ST_DROP: begin
            fifoOutReady = 1'b1;
            if (!fifoOutValid && s_reg.silence >= SILENCE_TICKS) begin
               s_next.st = ST_IDLE;
            end
         end
         ST_EXEC: begin
            s_next.st = ST_IDLE;
            s_next.txIdx = 8'h00;
            s_next.txCrc = CRC_INIT;
            s_next.crcLoHi = 1'b0;
            if (mine || bcast) begin
               s_next.st = bcast ? ST_IDLE : ST_SEND;
               s_next.txLen = 8'h06;
               if (fn == FC_READ_HOLDING) begin
                  if (val == 16'h0000 || val > MAX_READ_COUNT || {1'b0, addr} + {1'b0, val} > {1'b0, REG_COUNT}) begin
                     s_next.rxBuf[1] = fn | EXC_FLAG;
                     s_next.rxBuf[2] = (val == 16'h0000 || val > MAX_READ_COUNT) ?
                        EXC_ILLEGAL_VALUE : EXC_ILLEGAL_ADDR;
                     s_next.txLen = 8'h03;
                  end else begin
                     s_next.regIdx = addr;
                     s_next.regLeft = val;
                     s_next.rxBuf[2] = 8'(val << 1);
                     s_next.txLen = 8'(8'h03 + 8'(val << 1));
                  end
                  if (bcast) s_next.st = ST_IDLE;
               end else if (fn == FC_PRESET_REG) begin
                  case (addr)
                     REG_ACTIVE_SETPOINT: s_next.sp = clampS(val, procIn.setpointLowLimit,
                                                            procIn.setpointHighLimit);
                     REG_DISPLAY_VALUE: begin
                        s_next.disp = clampS(val, DISPLAY_MIN, DISPLAY_MAX);
                        s_next.dispStb = 1'b1;
                     end
                     REG_INTEGRAL_RATE: s_next.ir = clampS(val, 16'sd0, INTEGRAL_MAX);
                     REG_DERIVATIVE_TIME: s_next.dt = val;
                     REG_PROPORTIONAL_BAND: s_next.pb = clampS(val, 16'sd0, PROPBAND_MAX);
                     REG_PROGRAM_TIME_BASE: s_next.tb = clampS(val, 16'sd0, TIMEBASE_MAX);
                     REG_PWM_CYCLE_TIME: s_next.ct = clampS(val, PWM_MIN, PWM_MAX);
                     default: ;
                  endcase
               end else if (fn == FC_FORCE_COIL) begin
                  s_next.coilStb = 1'b1;
                  s_next.coilAddr = addr;
                  s_next.coilVal = val == 16'hff00;
               end else begin
                  s_next.rxBuf[1] = fn | EXC_FLAG;
                  s_next.rxBuf[2] = EXC_ILLEGAL_FUNC;
                  s_next.txLen = 8'h03;
               end
            end
         end
         ST_SEND: begin
            if (!s_reg.txBusy && tick) begin
               if (s_reg.txIdx < s_reg.txLen + 8'h02) begin
                  b = 8'h00;
                  w = readReg(s_reg.regIdx, s_reg, procIn);
                  if (s_reg.txIdx == s_reg.txLen) begin
                     b = s_reg.txCrc[7:0];
                  end else if (s_reg.txIdx == s_reg.txLen + 8'h01) begin
                     b = s_reg.txCrc[15:8];
                  end else if (fn == FC_READ_HOLDING && s_reg.txIdx >= 8'h03) begin
                     b = s_reg.crcLoHi ? w[7:0] : w[15:8];
                     s_next.crcLoHi = !s_reg.crcLoHi;
                     if (s_reg.crcLoHi) s_next.regIdx = s_reg.regIdx + 16'h0001;
                  end else begin
                     b = s_reg.rxBuf[s_reg.txIdx[2:0]];
                  end
                  if (s_reg.txIdx < s_reg.txLen) s_next.txCrc = crcStep(s_reg.txCrc, b);
                  s_next.txShift = {1'b1, b, 1'b0};
                  s_next.txBusy = 1'b1;
                  s_next.txEn = 1'b1;
                  s_next.txPhase = 4'h0;
                  s_next.txBit = 4'h0;
                  s_next.txIdx = s_reg.txIdx + 8'h01;
               end else begin
                  s_next.txEn = 1'b0;
                  s_next.st = ST_IDLE;
               end
            end
         end
         default: s_next.st = ST_IDLE;
      endcase

      // ---- transmitter ----
      if (s_reg.txBusy && tick) begin
         s_next.txLine = s_reg.txShift[0];
         s_next.txPhase = s_reg.txPhase + 4'h1;
         if (s_reg.txPhase == 4'hf) begin
            s_next.txShift = {1'b1, s_reg.txShift[9:1]};
            s_next.txBit = s_reg.txBit + 4'h1;
            if (s_reg.txBit == 4'h9) begin
               s_next.txBusy = 1'b0;
               s_next.txLine = 1'b1;
            end
         end
      end else if (!s_reg.txBusy) begin
         s_next.txLine = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
         s_reg.st <= ST_IDLE;
         s_reg.rxS1 <= 1'b1;
         s_reg.rxS2 <= 1'b1;
         s_reg.txLine <= 1'b1;
         s_reg.silence <= 16'hffff;
         s_reg.sp <= RST_SETPOINT;
         s_reg.disp <= RST_DISPLAY;
         s_reg.ir <= RST_INTEGRAL;
         s_reg.dt <= RST_DERIV;
         s_reg.pb <= RST_PROPBAND;
         s_reg.tb <= RST_TIMEBASE;
         s_reg.ct <= RST_PWM;
      end else begin
         s_reg <= s_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign txData = s_reg.txLine;
   assign txEnable = s_reg.txEn;
   assign screenSetpoint = s_reg.sp;
   assign displayWrite = s_reg.disp;
   assign displayWriteStrobe = s_reg.dispStb;
   assign integralRate = s_reg.ir;
   assign derivativeTime = s_reg.dt;
   assign proportionalBand = s_reg.pb;
   assign programTimeBase = s_reg.tb;
   assign pwmCycleTime = s_reg.ct;
   assign coilWriteStrobe = s_reg.coilStb;
   assign coilAddress = s_reg.coilAddr;
   assign coilValue = s_reg.coilVal;
endmodule
`default_nettype wire

// ==== testbench/mbs_slave_chk.sv ====
`default_nettype none
module mbs_slave_chk
   import mbs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic txData,
   input wire logic txEnable,
   input wire mbs_pkg::mbs_proc_s procIn,
   input wire logic signed [15:0] screenSetpoint,
   input wire logic signed [15:0] displayWrite,
   input wire logic displayWriteStrobe,
   input wire logic signed [15:0] integralRate,
   input wire logic signed [15:0] proportionalBand,
   input wire logic signed [15:0] pwmCycleTime,
   input wire logic coilWriteStrobe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************
   // port properties
   // ***************
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   a_idle_line_high: assert property (!txEnable |-> txData) else $error("tx line not idle high");
   a_start_bit_low: assert property ($fell(txData) |-> txEnable) else $error("start bit undriven");
   a_display_pulse: assert property (displayWriteStrobe |=> !displayWriteStrobe) else $error("long strobe");
   a_display_range: assert property (displayWriteStrobe |-> displayWrite >= DISPLAY_MIN &&
      displayWrite <= DISPLAY_MAX) else $error("display out of range");
   a_coil_pulse: assert property (coilWriteStrobe |=> !coilWriteStrobe) else $error("long coil strobe");
   a_integral_range: assert property (integralRate >= 0 && integralRate <= INTEGRAL_MAX)
      else $error("integral out of range");
   a_band_range: assert property (proportionalBand >= 0 && proportionalBand <= PROPBAND_MAX)
      else $error("band out of range");
   a_pwm_range: assert property ($changed(pwmCycleTime) |-> pwmCycleTime >= PWM_MIN &&
      pwmCycleTime <= PWM_MAX) else $error("pwm out of range");
   a_setpoint_limit: assert property ($changed(screenSetpoint) |->
      screenSetpoint >= procIn.setpointLowLimit && screenSetpoint <= procIn.setpointHighLimit)
      else $error("setpoint out of limits");
   c_reply: cover property ($rose(txEnable));
   c_display: cover property (displayWriteStrobe);
   c_coil: cover property (coilWriteStrobe);
endmodule
bind mbs_slave mbs_slave_chk chk (.clock(clock), .rst_b(rst_b), .txData(txData), .txEnable(txEnable),
   .procIn(procIn), .screenSetpoint(screenSetpoint), .displayWrite(displayWrite),
   .displayWriteStrobe(displayWriteStrobe), .integralRate(integralRate), .proportionalBand(proportionalBand),
   .pwmCycleTime(pwmCycleTime), .coilWriteStrobe(coilWriteStrobe));
`default_nettype wire

// ==== testbench/mbs_master_model.sv ====
`default_nettype none
module mbs_master_model #(
   parameter int BT = 32
) (
   input wire logic clock,
   input wire logic txData,
   input wire logic txEnable,
   output logic rxPin
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************
   // serial master
   // ***************
   logic [7:0] rxq[$];
   logic [7:0] rxb;
   initial rxPin = 1'b1;
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c = 16'hffff;
      foreach (b[i]) begin
         c ^= {8'h00, b[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   // silence, then 8n1 bytes lsb first, crc low byte first
   task automatic send(input logic [7:0] f[$], input logic bad);
      logic [15:0] c;
      c = crc16(f) ^ {15'h0000, bad};
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      rxq.delete();
      repeat (36 * BT) @(negedge clock);
      foreach (f[i]) begin
         rxPin = 1'b0;
         repeat (BT) @(negedge clock);
         for (int k = 0; k < 8; k++) begin
            rxPin = f[i][k];
            repeat (BT) @(negedge clock);
         end
         rxPin = 1'b1;
         repeat (BT) @(negedge clock);
      end
   endtask
   // reply bytes sampled mid-bit
   always @(posedge clock) begin
      if (txEnable && !txData) begin
         repeat (BT / 2) @(posedge clock);
         for (int k = 0; k < 8; k++) begin
            repeat (BT) @(posedge clock);
            rxb[k] = txData;
         end
         repeat (BT) @(posedge clock);
         rxq.push_back(rxb);
      end
   end
endmodule
`default_nettype wire

// ==== testbench/mbs_slave_tb.sv ====
`default_nettype none
module mbs_slave_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mbs_pkg::*;
   // ***************
   // bench
   // ***************
   localparam int DIV = 1;
   localparam logic [15:0] PID = 16'h1234; // arbitrary value
   typedef struct packed {logic [7:0] f; logic [15:0] r; logic [15:0] v; logic [15:0] e;} mbs_row_s;
   mbs_row_s rows [12] = '{
      '{FC_PRESET_REG, REG_PROPORTIONAL_BAND, 16'h01f4, 16'h01f4},
      '{FC_READ_HOLDING, REG_PROPORTIONAL_BAND, 16'h0001, 16'h01f4},
      '{FC_READ_HOLDING, REG_PRODUCT_IDENTITY, 16'h0001, PID},
      '{FC_READ_HOLDING, 16'h0003, 16'h0001, 16'h0000},
      '{FC_PRESET_REG, REG_FIRMWARE_VERSION, 16'h0005, 16'h0005},
      '{FC_READ_HOLDING, REG_FIRMWARE_VERSION, 16'h0001, 16'h0064},
      '{FC_READ_HOLDING, REG_PROCESS_VALUE, 16'h0001, 16'hfff0},
      '{FC_READ_HOLDING, REG_OUTPUT_POWER, 16'h0001, 16'h03e8},
      '{FC_READ_HOLDING, REG_SCREEN_INDEX, 16'h0001, 16'h0305},
      '{FC_FORCE_COIL, 16'h0002, 16'hff00, 16'hff00},
      '{FC_PRESET_REG, REG_DISPLAY_VALUE, 16'h2710, 16'h2710},
      '{FC_PRESET_REG, REG_ACTIVE_SETPOINT, 16'h0258, 16'h0258}};
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] node = NODE_MAX;
   mbs_proc_s proc = '0;
   logic rxPin, txData, txEnable, dispStb, coilStb, coilVal;
   logic signed [15:0] spOut, dispOut, intRate, derTime, band, timeBase, pwm;
   logic [15:0] coilAddr;
   int num_errors = 0;
   int checks = 0;
   always #2.5 clock = ~clock;
   mbs_slave #(.PRODUCT_ID(PID)) dut (.clock(clock), .rst_b(rst_b), .rxPin(rxPin), .txData(txData),
      .txEnable(txEnable), .lineSpeedSetting(16'(DIV)), .nodeAddress(node), .procIn(proc),
      .screenSetpoint(spOut), .displayWrite(dispOut), .displayWriteStrobe(dispStb), .integralRate(intRate),
      .derivativeTime(derTime), .proportionalBand(band), .programTimeBase(timeBase), .pwmCycleTime(pwm),
      .coilWriteStrobe(coilStb), .coilAddress(coilAddr), .coilValue(coilVal));
   mbs_master_model #(.BT(16 * DIV)) mdl (.clock(clock), .txData(txData), .txEnable(txEnable), .rxPin(rxPin));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] a, f, input logic [15:0] r, v, input logic bad);
      mdl.send({a, f, r[15:8], r[7:0], v[15:8], v[7:0]}, bad);
      for (int i = 0; i < 1500 && !txEnable; i++) @(negedge clock);
      for (int i = 0; i < 6000 && txEnable; i++) @(negedge clock);
   endtask
   task automatic rsp(input int n, input int i, input logic [15:0] exp);
      chk(16'(mdl.rxq.size()), 16'(n));
      if (mdl.rxq.size() > i + 1) begin
         chk(mdl.crc16(mdl.rxq), 16'h0000);
         chk({mdl.rxq[i], mdl.rxq[i + 1]}, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      proc.setpointLowLimit = -16'sd100;
      proc.setpointHighLimit = 16'sd500;
      proc.processValue = 16'shfff0;
      proc.outputPower = 16'sd1000;
      proc.screenIndex = 16'h0305;
      repeat (10) @(negedge clock);
      rst_b = 1'b1;
      chk(pwm, RST_PWM);
      foreach (rows[k]) begin
         xfer(node, rows[k].f, rows[k].r, rows[k].v, 1'b0);
         rsp(rows[k].f == FC_READ_HOLDING ? 7 : 8, rows[k].f == FC_READ_HOLDING ? 3 : 4, rows[k].e);
      end
      chk(spOut, proc.setpointHighLimit);
      chk(dispOut, DISPLAY_MAX);
      chk(coilAddr, 16'h0002);
      chk(16'(coilVal), 16'h0001);
      chk(derTime, RST_DERIV);
      chk(timeBase, RST_TIMEBASE);
      xfer(node, FC_READ_HOLDING, REG_INTEGRAL_RATE, 16'h0002, 1'b0);
      rsp(9, 3, RST_INTEGRAL);
      chk({mdl.rxq[5], mdl.rxq[6]}, RST_DERIV);
      xfer(node, FC_PRESET_REG, REG_INTEGRAL_RATE, 16'h0007, 1'b1);
      rsp(0, 0, 16'h0000);
      xfer(node - 8'h01, FC_PRESET_REG, REG_INTEGRAL_RATE, 16'h0007, 1'b0);
      rsp(0, 0, 16'h0000);
      chk(intRate, RST_INTEGRAL);
      xfer(BROADCAST_ADDR, FC_PRESET_REG, REG_PWM_CYCLE_TIME, 16'h07d0, 1'b0);
      rsp(0, 0, 16'h0000);
      chk(pwm, 16'h03e8);
      rst_b = 1'b0;
      @(negedge clock);
      rst_b = 1'b1;
      chk(pwm, RST_PWM);
      chk(band, RST_PROPBAND);
      xfer(node, 8'h10, 16'h0000, 16'h0000, 1'b0);
      rsp(5, 1, 16'h9001);
      print_verdict();
   end
   initial begin
      repeat (90000) @(negedge clock);
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
